// File: asr_host.sv
// Host controller that drives a one-bit asynchronous static memory by its pins.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Wait 100 us after power before access.
// - Write while select and strobe low, 7 ns.
// - Both select and strobe low start write.
// - Write data valid 6 ns before end.
// - Write data held through ending edge.
// - Address stable no later than write start.
// - Address stable 7 ns before, held after.
// - Write strobe high throughout every read.
// - Address valid by select falling edge.
module asr_host #(
   parameter int unsigned POWER_UP_CYCLES = asr_pkg::POWER_UP_CYCLES
) (
   // Clock and reset.
   input  wire logic                            clk_sys,
   input  wire logic                            reset,
   // User request side.
   input  wire logic                            req_valid,
   input  wire logic                            req_write,
   input  wire logic [asr_pkg::ADDR_WIDTH-1:0]  req_address,
   input  wire logic                            req_wdata,
   output logic                                 req_ready,
   output logic                                 rsp_valid,
   output logic                                 rsp_rdata,
   // Memory pins.
   output logic [asr_pkg::ADDR_WIDTH-1:0]       cell_address,
   output logic                                 chip_select_n,
   output logic                                 write_strobe_n,
   output logic                                 data_in,
   input  wire logic                            data_out
);

   // The counter spans the power-up wait or the longest access, whichever is longer.
   localparam int unsigned SPAN_MAX  = asr_pkg::READ_CYCLES + 3 + asr_pkg::WRITE_PULSE_CYCLES
                                       + asr_pkg::RECOVER_CYCLES;
   localparam int unsigned CNT_MAX   = (POWER_UP_CYCLES > SPAN_MAX) ? POWER_UP_CYCLES : SPAN_MAX;
   localparam int unsigned CNT_W     = $clog2(CNT_MAX + 1);
   localparam int unsigned PULSE_PS  = asr_pkg::WRITE_PULSE_CYCLES * asr_pkg::CLK_PERIOD_PS;
   localparam int unsigned ACCESS_PS = asr_pkg::READ_CYCLES_RAW * asr_pkg::CLK_PERIOD_PS;

   // Refuse a zero wait, and counts that would break pin timing at this clock rate.
   if (POWER_UP_CYCLES < 1) begin : g_bad_power_up
      $error("POWER_UP_CYCLES must be at least one");
   end
   if (PULSE_PS < asr_pkg::WRITE_PULSE_NS * 1000) begin : g_bad_pulse
      $error("write overlap shorter than the least pulse width");
   end
   if (ACCESS_PS < asr_pkg::ADDRESS_ACCESS_NS * 1000) begin : g_bad_access
      $error("read wait shorter than the access time");
   end
   if (asr_pkg::RECOVER_CYCLES < 1) begin : g_bad_recover
      $error("recovery span must be at least one cycle");
   end

   // State, counter and registered copies of every pin and output.
   asr_pkg::asr_state_t                  state_reg;
   asr_pkg::asr_state_t                  state_next;
   logic [CNT_W-1:0]                     count_reg;
   logic [CNT_W-1:0]                     count_next;
   logic [asr_pkg::ADDR_WIDTH-1:0]       addr_reg;
   logic [asr_pkg::ADDR_WIDTH-1:0]       addr_next;
   logic                                 cs_n_reg;
   logic                                 cs_n_next;
   logic                                 we_n_reg;
   logic                                 we_n_next;
   logic                                 din_reg;
   logic                                 din_next;
   logic                                 ready_reg;
   logic                                 ready_next;
   logic                                 rsp_valid_reg;
   logic                                 rsp_valid_next;
   logic                                 rdata_reg;
   logic                                 rdata_next;
   logic                                 dout_meta_reg;
   logic                                 dout_sync_reg;

   // The data pin is asynchronous to clk_sys, so it passes two flip-flops first.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dout_meta_reg <= 1'b0;
         dout_sync_reg <= 1'b0;
      end else begin
         dout_meta_reg <= data_out;
         dout_sync_reg <= dout_meta_reg;
      end
   end

   // Sequence the pins; the address is set a whole cycle before any strobe falls.
   always_comb begin
      state_next     = state_reg;
      count_next     = count_reg;
      addr_next      = addr_reg;
      cs_n_next      = cs_n_reg;
      we_n_next      = we_n_reg;
      din_next       = din_reg;
      ready_next     = 1'b0;
      rsp_valid_next = 1'b0;
      rdata_next     = rdata_reg;
      case (state_reg)
         asr_pkg::ASR_POWER_UP: begin
            // No access before the supply has settled.
            if (count_reg == CNT_W'(POWER_UP_CYCLES - 1)) begin
               state_next = asr_pkg::ASR_IDLE;
               count_next = '0;
               ready_next = 1'b1;
            end else begin
               count_next = count_reg + CNT_W'(1);
            end
         end
         asr_pkg::ASR_IDLE: begin
            // Deselected between accesses so the memory sits in standby.
            cs_n_next  = 1'b1;
            we_n_next  = 1'b1;
            ready_next = 1'b1;
            if (req_valid && ready_reg) begin
               ready_next = 1'b0;
               addr_next  = req_address;
               din_next   = req_wdata;
               count_next = '0;
               state_next = req_write ? asr_pkg::ASR_WRITE_SETUP : asr_pkg::ASR_READ;
            end
         end
         asr_pkg::ASR_READ: begin
            // Select falls after the address has stood one cycle; strobe stays high.
            cs_n_next = 1'b0;
            we_n_next = 1'b1;
            count_next = count_reg + CNT_W'(1);
            // Wait access time plus the two synchroniser stages before capture.
            if (count_reg == CNT_W'(asr_pkg::READ_CYCLES + 2)) begin
               rdata_next     = dout_sync_reg;
               rsp_valid_next = 1'b1;
               cs_n_next      = 1'b1;
               state_next     = asr_pkg::ASR_RECOVER;
               count_next     = '0;
            end
         end
         asr_pkg::ASR_WRITE_SETUP: begin
            // Both strobes fall together; the address has settled a cycle earlier.
            cs_n_next  = 1'b0;
            we_n_next  = 1'b0;
            count_next = '0;
            state_next = asr_pkg::ASR_WRITE_PULSE;
         end
         asr_pkg::ASR_WRITE_PULSE: begin
            // Overlap covers pulse width, data setup and address setup.
            count_next = count_reg + CNT_W'(1);
            if (count_reg == CNT_W'(asr_pkg::WRITE_PULSE_CYCLES - 1)) begin
               // Both strobes rise together; address and data stay put this edge.
               we_n_next  = 1'b1;
               cs_n_next  = 1'b1;
               count_next = '0;
               state_next = asr_pkg::ASR_RECOVER;
            end
         end
         asr_pkg::ASR_RECOVER: begin
            // Hold address and data one more span so the next cycle starts clean.
            count_next = count_reg + CNT_W'(1);
            if (count_reg == CNT_W'(asr_pkg::RECOVER_CYCLES - 1)) begin
               count_next = '0;
               ready_next = 1'b1;
               state_next = asr_pkg::ASR_IDLE;
            end
         end
         default: begin
            state_next = asr_pkg::ASR_IDLE;
            cs_n_next  = 1'b1;
            we_n_next  = 1'b1;
         end
      endcase
   end

   // Register all state; pins come straight from these flip-flops.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg     <= asr_pkg::ASR_POWER_UP;
         count_reg     <= '0;
         addr_reg      <= '0;
         cs_n_reg      <= 1'b1;
         we_n_reg      <= 1'b1;
         din_reg       <= 1'b0;
         ready_reg     <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rdata_reg     <= 1'b0;
      end else begin
         state_reg     <= state_next;
         count_reg     <= count_next;
         addr_reg      <= addr_next;
         cs_n_reg      <= cs_n_next;
         we_n_reg      <= we_n_next;
         din_reg       <= din_next;
         ready_reg     <= ready_next;
         rsp_valid_reg <= rsp_valid_next;
         rdata_reg     <= rdata_next;
      end
   end

   // Every output is a flip-flop, so the pins never glitch between edges.
   assign req_ready      = ready_reg;
   assign rsp_valid      = rsp_valid_reg;
   assign rsp_rdata      = rdata_reg;
   assign cell_address   = addr_reg;
   assign chip_select_n  = cs_n_reg;
   assign write_strobe_n = we_n_reg;
   assign data_in        = din_reg;

endmodule : asr_host

`default_nettype wire

// File: asr_pkg.sv
// Package with timing constants and states for the static memory host controller.
package asr_pkg;

   // Clock period of clk_sys in picoseconds (250 MHz).
   localparam int unsigned CLK_PERIOD_PS = 4000;

   // Pin timing figures in nanoseconds, and power-up wait in microseconds.
   localparam int unsigned POWER_UP_US          = 100;
   localparam int unsigned READ_CYCLE_NS        = 10;
   localparam int unsigned ADDRESS_ACCESS_NS    = 10;
   localparam int unsigned WRITE_PULSE_NS       = 7;
   localparam int unsigned WRITE_DATA_SETUP_NS  = 6;
   localparam int unsigned ADDR_SETUP_END_NS    = 7;
   localparam int unsigned WRITE_CYCLE_NS       = 10;
   localparam int unsigned OUTPUT_OFF_NS        = 6;

   // Least times round up to whole cycles; every count is at least one.
   localparam int unsigned POWER_UP_CYCLES =
      (POWER_UP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned READ_CYCLES_RAW =
      (ADDRESS_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Add one cycle so the pin is sampled after the access time, then two
   // synchroniser stages delay the captured value further.
   localparam int unsigned READ_CYCLES = READ_CYCLES_RAW + 1;
   localparam int unsigned WRITE_PULSE_RAW =
      (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned WRITE_PULSE_CYCLES =
      (WRITE_PULSE_RAW < 1) ? 1 : WRITE_PULSE_RAW;
   // Gap after every read or write ends, before the next access, lets the output driver settle.
   localparam int unsigned RECOVER_CYCLES =
      (OUTPUT_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Width of the memory cell address.
   localparam int unsigned ADDR_WIDTH = 20;

   // Controller states.
   typedef enum logic [2:0] {
      ASR_POWER_UP,
      ASR_IDLE,
      ASR_READ,
      ASR_WRITE_SETUP,
      ASR_WRITE_PULSE,
      ASR_RECOVER
   } asr_state_t;

endpackage : asr_pkg

// File: asr_mem_model.sv
// Behavioural one-bit static memory on the far side of the host.
`timescale 1ns/1ps
`default_nettype none
module asr_mem_model #(
   parameter int unsigned ACCESS_NS = 8
) (
   // Memory pins.
   input  wire logic [asr_pkg::ADDR_WIDTH-1:0] cell_address,
   input  wire logic                           chip_select_n,
   input  wire logic                           write_strobe_n,
   input  wire logic                           data_in,
   output logic                                data_out
);
   bit   mem [0:(1<<asr_pkg::ADDR_WIDTH)-1];
   logic wr_on;
   assign wr_on = !chip_select_n && !write_strobe_n;
   // The bit is stored when the first strobe rises, so a deselected part never stores.
   always @(negedge wr_on) mem[cell_address] = data_in;
   // A floating pin shows the inverse of its last value so stale data is never trusted.
   initial data_out = 1'b0;
   always @(chip_select_n, write_strobe_n, cell_address) begin
      if (!chip_select_n && write_strobe_n)
         data_out <= #(ACCESS_NS) mem[cell_address];
      else
         data_out <= #2 ~data_out;
   end
endmodule : asr_mem_model
`default_nettype wire

// File: asr_host_properties.sv
// Assertions on the host controller's request and memory pins.
`timescale 1ns/1ps
`default_nettype none
module asr_host_properties #(
   parameter int unsigned POWER_UP_CYCLES = asr_pkg::POWER_UP_CYCLES
) (
   // Clock and reset.
   input wire logic                           clk_sys,
   input wire logic                           reset,
   // Request side.
   input wire logic                           req_valid,
   input wire logic                           req_ready,
   input wire logic                           rsp_valid,
   // Memory pins.
   input wire logic [asr_pkg::ADDR_WIDTH-1:0] cell_address,
   input wire logic                           chip_select_n,
   input wire logic                           write_strobe_n,
   input wire logic                           data_in
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   int unsigned pu_cnt_reg;
   int unsigned pu_cnt_next;
   // Edges since reset, saturating, to time the first grant.
   always_comb begin
      pu_cnt_next = (pu_cnt_reg < POWER_UP_CYCLES) ? pu_cnt_reg + 1 : pu_cnt_reg;
   end
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset)
         pu_cnt_reg <= 0;
      else
         pu_cnt_reg <= pu_cnt_next;
   end
   chk_power_wait: assert property (req_ready |-> pu_cnt_reg >= POWER_UP_CYCLES)
      else $error("grant before power-up wait");
   chk_write_start: assert property ($fell(write_strobe_n) |-> $fell(chip_select_n))
      else $error("strobes do not fall together");
   chk_write_addr: assert property ($fell(write_strobe_n) |-> $stable(cell_address))
      else $error("address moves at write start");
   chk_pulse_width: assert property ($fell(write_strobe_n) |-> (!write_strobe_n && !chip_select_n)[*2])
      else $error("write overlap too short");
   chk_write_end: assert property ($fell(write_strobe_n) |-> ##2 (write_strobe_n && chip_select_n))
      else $error("write not ended in time");
   chk_data_hold: assert property ((!chip_select_n && !write_strobe_n) |=> $stable(data_in) && $stable(cell_address))
      else $error("data or address moves in write");
   chk_read_strobe: assert property (($fell(chip_select_n) && write_strobe_n) |-> (write_strobe_n && !chip_select_n)[*6])
      else $error("strobe low in read");
   chk_read_addr: assert property (($fell(chip_select_n) && write_strobe_n) |-> $stable(cell_address))
      else $error("address moves at select");
   chk_read_answer: assert property (($fell(chip_select_n) && write_strobe_n) |-> ##6 rsp_valid)
      else $error("read answer late");
   chk_take_order: assert property ((req_valid && req_ready) |=> !req_ready ##1 !chip_select_n)
      else $error("take not followed by select");
endmodule : asr_host_properties
`default_nettype wire
bind asr_host asr_host_properties #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) u_asr_host_properties (
   .clk_sys(clk_sys), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
   .rsp_valid(rsp_valid), .cell_address(cell_address), .chip_select_n(chip_select_n),
   .write_strobe_n(write_strobe_n), .data_in(data_in));

// File: asr_host_tb_top.sv
// Self-checking testbench for the static memory host controller.
`timescale 1ns/1ps
`default_nettype none
module asr_host_tb_top;
   localparam int unsigned PU = 20;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic req_wdata = 1'b0;
   logic [asr_pkg::ADDR_WIDTH-1:0] req_address = '0;
   logic [asr_pkg::ADDR_WIDTH-1:0] cell_address;
   logic req_ready, rsp_valid, rsp_rdata, chip_select_n, write_strobe_n, data_in, data_out;
   int   bad_count = 0;
   int   total_checks = 0;
   // Free-running 250 MHz clock.
   always #2 clk_sys = ~clk_sys;
   asr_host #(.POWER_UP_CYCLES(PU)) u_asr_host (.clk_sys(clk_sys), .reset(reset),
      .req_valid(req_valid), .req_write(req_write), .req_address(req_address),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .cell_address(cell_address), .chip_select_n(chip_select_n),
      .write_strobe_n(write_strobe_n), .data_in(data_in), .data_out(data_out));
   asr_mem_model u_asr_mem_model (.cell_address(cell_address), .chip_select_n(chip_select_n),
      .write_strobe_n(write_strobe_n), .data_in(data_in), .data_out(data_out));
   task automatic check(input logic got, input logic exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic end_of_test();
      if (bad_count == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   // Holds the request through the taking edge, then waits a bounded time for completion.
   task automatic do_op(input logic wr, input logic [19:0] a, input logic d, input logic exp);
      int n;
      req_valid = 1'b1;
      req_write = wr;
      req_address = a;
      req_wdata = d;
      n = 0;
      while (req_ready !== 1'b1 && n < 200) begin
         @(posedge clk_sys);
         #1 n++;
      end
      check(req_ready, 1'b1, "no grant");
      // The grant seen here is what the next edge samples, so that edge takes the request.
      @(posedge clk_sys);
      #1 req_valid = 1'b0;
      n = 0;
      while ((wr ? req_ready : rsp_valid) !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (wr) begin
         check(req_ready, 1'b1, "write not finished");
      end else begin
         check(rsp_valid, 1'b1, "no read answer");
         check(rsp_rdata, exp, "read data");
         @(posedge clk_sys);
         #1 check(rsp_valid, 1'b0, "answer stands too long");
      end
   endtask : do_op
   // No grant may appear before the power-up wait has run out, and it comes on its last edge.
   task automatic t_power();
      repeat (PU - 1) begin
         @(posedge clk_sys);
         #1 check(req_ready, 1'b0, "early grant");
      end
      @(posedge clk_sys);
      #1 check(req_ready, 1'b1, "late grant");
   endtask : t_power
   // Boundary and pattern addresses, then an overwrite, then another written cell left untouched.
   task automatic t_data();
      logic [19:0] adr [4] = '{20'h00000, 20'hFFFFF, 20'h5A5A5, 20'hA5A5A};
      for (int i = 0; i < 4; i++)
         do_op(1'b1, adr[i], i[0], 1'b0);
      for (int i = 0; i < 4; i++)
         do_op(1'b0, adr[i], 1'b0, i[0]);
      do_op(1'b1, adr[0], 1'b1, 1'b0);
      do_op(1'b0, adr[0], 1'b0, 1'b1);
      do_op(1'b0, adr[1], 1'b0, 1'b1);
   endtask : t_data
   // Reset in mid-write must release the strobes at once and restart the wait.
   task automatic t_reset_mid();
      int n;
      req_valid = 1'b1;
      req_write = 1'b1;
      req_address = 20'h12345;
      n = 0;
      while (chip_select_n !== 1'b0 && n < 300) begin
         @(posedge clk_sys);
         #1 n++;
      end
      check(chip_select_n, 1'b0, "write never started");
      req_valid = 1'b0;
      reset = 1'b1;
      #1 check(write_strobe_n & chip_select_n, 1'b1, "strobes after reset");
      repeat (6) @(posedge clk_sys);
      #1 reset = 1'b0;
      t_power();
      do_op(1'b0, 20'hFFFFF, 1'b0, 1'b1);
   endtask : t_reset_mid
   // Main sequence.
   initial begin
      repeat (6) @(posedge clk_sys);
      #1 reset = 1'b0;
      t_power();
      t_data();
      t_reset_mid();
      end_of_test();
   end
   // Watchdog, far beyond the less than one microsecond the tests need.
   initial begin
      #100000;
      bad_count++;
      end_of_test();
   end
endmodule : asr_host_tb_top
`default_nettype wire
